// file: rtl/itv_top.sv
// The implementer's own choices: the strobed register port and the register offsets.
`default_nettype none
module itv_top (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_nrst,
   input  wire logic [itv_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic [itv_pkg::DATA_W-1:0]    i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output var  logic [itv_pkg::DATA_W-1:0]    o_rdata,
   input  wire logic [itv_pkg::N_SRC-1:0]     i_src_req,
   input  wire logic                          i_nmi,
   input  wire logic                          i_stack_over,
   input  wire logic                          i_stack_under,
   input  wire logic                          i_undef_opcode,
   input  wire logic                          i_prot_fault,
   input  wire logic                          i_illegal_operand,
   input  wire logic                          i_illegal_instr,
   input  wire logic                          i_illegal_bus,
   input  wire logic                          i_sw_reset,
   input  wire logic                          i_wdt_overflow,
   input  wire logic                          i_swtrap_req,
   input  wire logic [itv_pkg::NUM_W-1:0]     i_swtrap_num,
   input  wire logic [itv_pkg::PRIO_W-1:0]    i_cpu_prio,
   input  wire logic                          i_vec_ack,
   input  wire logic                          i_trap_return,
   output var  logic                          o_vec_valid,
   output var  logic [itv_pkg::VEC_W-1:0]     o_vec_addr,
   output var  logic [itv_pkg::NUM_W-1:0]     o_trap_num,
   output var  logic [itv_pkg::PRIO_W-1:0]    o_new_prio,
   output var  logic [2:0]                    o_kind,
   output var  logic                          o_hw_trap_active,
   output var  logic                          o_irq
);
   localparam int N = itv_pkg::N_SRC;

   function automatic logic src_hit(input logic [itv_pkg::ADDR_W-1:0] a);
      src_hit = (a >= itv_pkg::OFS_SRC_BASE) && (a[1:0] == 2'b00) &&
                (a < itv_pkg::OFS_SRC_BASE + itv_pkg::ADDR_W'(4 * N));
   endfunction

   function automatic logic [itv_pkg::IDX_W-1:0] src_idx(input logic [itv_pkg::ADDR_W-1:0] a);
      logic [itv_pkg::ADDR_W-1:0] d;
      d = a - itv_pkg::OFS_SRC_BASE;
      src_idx = d[itv_pkg::IDX_W+1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Flags and arbiter

   logic [itv_pkg::N_FLAG-1:0] flag_set;
   logic [itv_pkg::N_FLAG-1:0] flag_clr;
   logic [itv_pkg::N_FLAG-1:0] exc_flags;
   itv_src_if                  src ();

   always_comb begin
      flag_set = '0;
      flag_set[itv_pkg::F_NMI] = i_nmi;
      flag_set[itv_pkg::F_STK_OVER] = i_stack_over;
      flag_set[itv_pkg::F_STK_UNDER] = i_stack_under;
      flag_set[itv_pkg::F_UNDEF_OPC] = i_undef_opcode;
      flag_set[itv_pkg::F_PROT_FAULT] = i_prot_fault;
      flag_set[itv_pkg::F_ILL_OPERAND] = i_illegal_operand;
      flag_set[itv_pkg::F_ILL_INSTR] = i_illegal_instr;
      flag_set[itv_pkg::F_ILL_BUS] = i_illegal_bus;
      flag_clr = (i_wr && i_addr == itv_pkg::OFS_EXC_FLAGS) ?
                 i_wdata[itv_pkg::N_FLAG-1:0] : '0;
   end

   itv_trap_flags #(.W(itv_pkg::N_FLAG)) u_flags (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_set      (flag_set),
      .i_clr      (flag_clr),
      .o_flags    (exc_flags)
   );

   itv_irq_arb u_arb (
      .src (src)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State

   itv_pkg::itv_state_e        state;
   itv_pkg::itv_state_e        next_state;
   itv_pkg::itv_kind_e         kind;
   itv_pkg::itv_kind_e         next_kind;
   logic [N-1:0]               req;
   logic [N-1:0]               next_req;
   logic [N-1:0]               en;
   logic [N-1:0]               next_en;
   logic [itv_pkg::PRIO_W-1:0] lvl [N];
   logic [itv_pkg::PRIO_W-1:0] next_lvl [N];
   logic [2:0]                 pend_a;
   logic [2:0]                 next_pend_a;
   logic                       pend_b;
   logic                       next_pend_b;
   logic                       pend_rst;
   logic                       next_pend_rst;
   logic                       pend_sw;
   logic                       next_pend_sw;
   logic [itv_pkg::NUM_W-1:0]  sw_num;
   logic [itv_pkg::NUM_W-1:0]  next_sw_num;
   logic                       active_a;
   logic                       next_active_a;
   logic                       active_b;
   logic                       next_active_b;
   logic [itv_pkg::N_EVT-1:0]  evt_st;
   logic [itv_pkg::N_EVT-1:0]  next_evt_st;
   logic [itv_pkg::N_EVT-1:0]  evt_en;
   logic [itv_pkg::N_EVT-1:0]  next_evt_en;
   logic [itv_pkg::N_EVT-1:0]  evt_set;
   logic                       next_vec_valid;
   logic [itv_pkg::NUM_W-1:0]  next_trap_num;
   logic [itv_pkg::PRIO_W-1:0] next_new_prio;
   logic [itv_pkg::DATA_W-1:0] next_rdata;
   logic                       next_irq;

   assign src.req = req;
   assign src.en = en;
   assign src.lvl = lvl;
   assign src.floor = i_cpu_prio;

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_req = req;
      next_en = en;
      next_lvl = lvl;
      next_pend_a = pend_a | {i_stack_under, i_stack_over, i_nmi};
      next_pend_b = pend_b | i_undef_opcode | i_prot_fault | i_illegal_operand |
                    i_illegal_instr | i_illegal_bus;
      next_pend_rst = pend_rst | i_sw_reset | i_wdt_overflow;
      next_pend_sw = pend_sw;
      next_sw_num = sw_num;
      next_active_a = active_a;
      next_active_b = active_b;
      next_vec_valid = o_vec_valid;
      next_trap_num = o_trap_num;
      next_new_prio = o_new_prio;
      next_evt_en = evt_en;
      evt_set = '0;
      next_rdata = '0;

      if (i_swtrap_req) begin
         next_pend_sw = 1'b1;
         next_sw_num = i_swtrap_num;
      end

      // Register writes; source requests below win over a software clear
      if (i_wr) begin
         if (i_addr == itv_pkg::OFS_EVT_ENABLE) begin
            next_evt_en = i_wdata[itv_pkg::N_EVT-1:0];
         end else if (src_hit(i_addr)) begin
            next_lvl[src_idx(i_addr)] = i_wdata[itv_pkg::S_LVL_LSB +: itv_pkg::PRIO_W];
            next_en[src_idx(i_addr)] = i_wdata[itv_pkg::S_EN];
            next_req[src_idx(i_addr)] = i_wdata[itv_pkg::S_REQ];
         end
      end
      next_req = next_req | i_src_req;

      // Return from a hardware trap handler closes the innermost one
      if (i_trap_return) begin
         if (active_a) begin
            next_active_a = 1'b0;
         end else begin
            next_active_b = 1'b0;
         end
      end

      case (state)
         itv_pkg::ST_IDLE: begin
            if (pend_rst) begin
               next_pend_rst = i_sw_reset | i_wdt_overflow;
               next_kind = itv_pkg::KIND_RESTART;
               next_trap_num = itv_pkg::TRAP_RESTART;
               next_new_prio = itv_pkg::PRIO_TOP;
               next_vec_valid = 1'b1;
               next_state = itv_pkg::ST_OFFER;
            end else if (pend_a != 3'b000 && !active_a) begin
               next_kind = itv_pkg::KIND_CLASS_A;
               next_new_prio = itv_pkg::PRIO_TOP;
               next_vec_valid = 1'b1;
               next_state = itv_pkg::ST_OFFER;
               if (pend_a[0]) begin
                  next_pend_a[0] = i_nmi;
                  next_trap_num = itv_pkg::TRAP_NONMASKABLE;
               end else if (pend_a[1]) begin
                  next_pend_a[1] = i_stack_over;
                  next_trap_num = itv_pkg::TRAP_STACK_OVER;
               end else begin
                  next_pend_a[2] = i_stack_under;
                  next_trap_num = itv_pkg::TRAP_STACK_UNDER;
               end
            end else if (pend_b && !active_a && !active_b) begin
               next_pend_b = i_undef_opcode | i_prot_fault | i_illegal_operand |
                             i_illegal_instr | i_illegal_bus;
               next_kind = itv_pkg::KIND_CLASS_B;
               next_trap_num = itv_pkg::TRAP_CLASS_B;
               next_new_prio = itv_pkg::PRIO_TOP;
               next_vec_valid = 1'b1;
               next_state = itv_pkg::ST_OFFER;
            end else if (pend_sw) begin
               next_pend_sw = i_swtrap_req;
               next_kind = itv_pkg::KIND_SW;
               next_trap_num = sw_num;
               next_new_prio = i_cpu_prio;
               next_vec_valid = 1'b1;
               next_state = itv_pkg::ST_OFFER;
            end else if (src.hit && !active_a && !active_b) begin
               next_req[src.idx] = i_src_req[src.idx];
               next_kind = itv_pkg::KIND_IRQ;
               next_trap_num = itv_pkg::SRC_TRAP[src.idx];
               next_new_prio = src.win_lvl;
               next_vec_valid = 1'b1;
               next_state = itv_pkg::ST_OFFER;
            end
         end
         itv_pkg::ST_OFFER: begin
            if (i_vec_ack) begin
               next_vec_valid = 1'b0;
               next_state = itv_pkg::ST_IDLE;
               case (kind)
                  itv_pkg::KIND_RESTART: begin
                     next_active_a = 1'b0;
                     next_active_b = 1'b0;
                     evt_set[itv_pkg::E_RESTART] = 1'b1;
                  end
                  itv_pkg::KIND_CLASS_A: begin
                     next_active_a = 1'b1;
                     evt_set[itv_pkg::E_HW_TRAP] = 1'b1;
                  end
                  itv_pkg::KIND_CLASS_B: begin
                     next_active_b = 1'b1;
                     evt_set[itv_pkg::E_HW_TRAP] = 1'b1;
                  end
                  itv_pkg::KIND_SW: begin
                     evt_set[itv_pkg::E_SW_TRAP] = 1'b1;
                  end
                  default: begin
                     evt_set[itv_pkg::E_IRQ] = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            next_state = itv_pkg::ST_IDLE;
         end
      endcase

      // Event status: set wins over a clear written in the same cycle
      next_evt_st = evt_st;
      if (i_wr && i_addr == itv_pkg::OFS_EVT_CLEAR) begin
         next_evt_st = next_evt_st & ~i_wdata[itv_pkg::N_EVT-1:0];
      end
      next_evt_st = next_evt_st | evt_set;
      next_irq = |(next_evt_st & next_evt_en);

      // Read data stand only in the cycle after the strobe
      if (i_rd) begin
         if (i_addr == itv_pkg::OFS_EXC_FLAGS) begin
            next_rdata = itv_pkg::DATA_W'(exc_flags);
         end else if (i_addr == itv_pkg::OFS_EVT_STATUS) begin
            next_rdata = itv_pkg::DATA_W'(evt_st);
         end else if (i_addr == itv_pkg::OFS_EVT_ENABLE) begin
            next_rdata = itv_pkg::DATA_W'(evt_en);
         end else if (i_addr == itv_pkg::OFS_SERVICE) begin
            next_rdata = itv_pkg::DATA_W'({pend_rst, pend_sw, pend_b, pend_a,
                                           active_b, active_a, state == itv_pkg::ST_OFFER});
         end else if (src_hit(i_addr)) begin
            next_rdata = itv_pkg::DATA_W'({req[src_idx(i_addr)], en[src_idx(i_addr)],
                                           2'b00, lvl[src_idx(i_addr)]});
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= itv_pkg::ST_IDLE;
         kind <= itv_pkg::KIND_RESTART;
         req <= '0;
         en <= '0;
         lvl <= '{default: '0};
         pend_a <= 3'h0;
         pend_b <= 1'b0;
         pend_rst <= 1'b1;
         pend_sw <= 1'b0;
         sw_num <= '0;
         active_a <= 1'b0;
         active_b <= 1'b0;
         evt_st <= '0;
         evt_en <= '0;
         o_vec_valid <= 1'b0;
         o_trap_num <= '0;
         o_new_prio <= '0;
         o_rdata <= '0;
         o_irq <= 1'b0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         req <= next_req;
         en <= next_en;
         lvl <= next_lvl;
         pend_a <= next_pend_a;
         pend_b <= next_pend_b;
         pend_rst <= next_pend_rst;
         pend_sw <= next_pend_sw;
         sw_num <= next_sw_num;
         active_a <= next_active_a;
         active_b <= next_active_b;
         evt_st <= next_evt_st;
         evt_en <= next_evt_en;
         o_vec_valid <= next_vec_valid;
         o_trap_num <= next_trap_num;
         o_new_prio <= next_new_prio;
         o_rdata <= next_rdata;
         o_irq <= next_irq;
      end
   end

   // Derived copies kept as flops so every output leaves a register
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_vec_addr <= '0;
         o_kind <= 3'h0;
         o_hw_trap_active <= 1'b0;
      end else begin
         o_vec_addr <= itv_pkg::vec_of(next_trap_num);
         o_kind <= next_kind;
         o_hw_trap_active <= next_active_a | next_active_b;
      end
   end
endmodule // itv_top
`default_nettype wire

// file: common/itv_pkg.sv
`default_nettype none
package itv_pkg;
   localparam int N_SRC = 26;
   localparam int IDX_W = 5;
   localparam int PRIO_W = 4;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int NUM_W = 7;
   localparam int VEC_W = 24;

   // Trap numbers of the peripheral sources, by source index
   localparam logic [NUM_W-1:0] SRC_TRAP [N_SRC] = '{
      7'h24, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f,
      7'h30, 7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3a, 7'h3b,
      7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h43, 7'h47, 7'h4d, 7'h4e, 7'h4f};
   localparam int SRC_TIMER_FOUR = 0;
   localparam int SRC_NODE_ZERO = 20;
   localparam int SRC_NODE_THREE = 21;

   localparam logic [NUM_W-1:0] TRAP_RESTART = 7'h00;
   localparam logic [NUM_W-1:0] TRAP_NONMASKABLE = 7'h02;
   localparam logic [NUM_W-1:0] TRAP_STACK_OVER = 7'h04;
   localparam logic [NUM_W-1:0] TRAP_STACK_UNDER = 7'h06;
   localparam logic [NUM_W-1:0] TRAP_CLASS_B = 7'h0a;
   localparam logic [NUM_W-1:0] TRAP_RSV_LO = 7'h0b;
   localparam logic [NUM_W-1:0] TRAP_RSV_HI = 7'h0f;
   localparam logic [NUM_W-1:0] TRAP_SW_MAX = 7'h7f;
   localparam logic [PRIO_W-1:0] PRIO_TOP = 4'hf;

   // Exception flag register bit positions
   localparam int F_NMI = 0;
   localparam int F_STK_OVER = 1;
   localparam int F_STK_UNDER = 2;
   localparam int F_UNDEF_OPC = 3;
   localparam int F_PROT_FAULT = 4;
   localparam int F_ILL_OPERAND = 5;
   localparam int F_ILL_INSTR = 6;
   localparam int F_ILL_BUS = 7;
   localparam int N_FLAG = 8;

   // Event status bits
   localparam int E_HW_TRAP = 0;
   localparam int E_SW_TRAP = 1;
   localparam int E_RESTART = 2;
   localparam int E_IRQ = 3;
   localparam int N_EVT = 4;

   // Source control word fields
   localparam int S_LVL_LSB = 0;
   localparam int S_EN = 6;
   localparam int S_REQ = 7;

   localparam logic [ADDR_W-1:0] OFS_EXC_FLAGS = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_SERVICE = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_SRC_BASE = 12'h100;

   typedef enum logic [2:0] {KIND_RESTART, KIND_CLASS_A, KIND_CLASS_B, KIND_SW, KIND_IRQ}
      itv_kind_e;
   typedef enum logic {ST_IDLE, ST_OFFER} itv_state_e;

   // Vector location is four times the trap number
   function automatic logic [VEC_W-1:0] vec_of(input logic [NUM_W-1:0] num);
      vec_of = {15'h0000, num, 2'b00};
   endfunction
endpackage
`default_nettype wire

// file: common/itv_src_if.sv
`default_nettype none
interface itv_src_if;
   logic [itv_pkg::N_SRC-1:0]  req;
   logic [itv_pkg::N_SRC-1:0]  en;
   logic [itv_pkg::PRIO_W-1:0] lvl [itv_pkg::N_SRC];
   logic [itv_pkg::PRIO_W-1:0] floor;
   logic                       hit;
   logic [itv_pkg::IDX_W-1:0]  idx;
   logic [itv_pkg::PRIO_W-1:0] win_lvl;
   modport arb (input req, en, lvl, floor, output hit, idx, win_lvl);
   modport ctl (output req, en, lvl, floor, input hit, idx, win_lvl);
endinterface
`default_nettype wire

// file: rtl/itv_trap_flags.sv
`default_nettype none
module itv_trap_flags #(
   parameter int W = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_nrst,
   input  wire logic [W-1:0] i_set,
   input  wire logic [W-1:0] i_clr,
   output var  logic [W-1:0] o_flags
);
   logic [W-1:0] next_flags;

   // Sticky until cleared; a set in the clear cycle survives
   always_comb begin
      next_flags = (o_flags & ~i_clr) | i_set;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_flags <= '0;
      end else begin
         o_flags <= next_flags;
      end
   end
endmodule // itv_trap_flags
`default_nettype wire

// file: rtl/itv_irq_arb.sv
`default_nettype none
module itv_irq_arb (
   itv_src_if.arb src
);
   // Strictly higher level wins, so equal levels keep the lowest index
   always_comb begin
      src.hit = 1'b0;
      src.idx = '0;
      src.win_lvl = '0;
      for (int i = 0; i < itv_pkg::N_SRC; i++) begin
         if (src.req[i] && src.en[i] && (src.lvl[i] > src.floor) &&
             (!src.hit || (src.lvl[i] > src.win_lvl))) begin
            src.hit = 1'b1;
            src.idx = itv_pkg::IDX_W'(i);
            src.win_lvl = src.lvl[i];
         end
      end
   end
endmodule // itv_irq_arb
`default_nettype wire

// file: tb/itv_top_properties.sv
`default_nettype none
module itv_top_properties (
   input wire logic        i_core_clk,
   input wire logic        i_nrst,
   input wire logic        i_nmi,
   input wire logic        i_vec_ack,
   input wire logic [3:0]  i_cpu_prio,
   input wire logic        o_vec_valid,
   input wire logic [23:0] o_vec_addr,
   input wire logic [6:0]  o_trap_num,
   input wire logic [3:0]  o_new_prio,
   input wire logic [2:0]  o_kind,
   input wire logic        o_hw_trap_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   property p_vec;
      o_vec_valid |-> o_vec_addr == {15'h0000, o_trap_num, 2'b00};
   endproperty
   a_vec: assert property (p_vec) else $error("vector not four times trap");
   property p_class_a;
      o_vec_valid && o_kind == 3'h1 |-> o_trap_num inside {7'h02, 7'h04, 7'h06};
   endproperty
   a_class_a: assert property (p_class_a) else $error("bad class A trap");
   property p_class_b;
      o_vec_valid && o_kind == 3'h2 |-> o_trap_num == 7'h0a && o_new_prio == 4'hf;
   endproperty
   a_class_b: assert property (p_class_b) else $error("bad class B trap");
   property p_irq_blk;
      $rose(o_vec_valid) && o_hw_trap_active |-> o_kind != 3'h4;
   endproperty
   a_irq_blk: assert property (p_irq_blk) else $error("irq during trap");
   property p_sw_prio;
      $rose(o_vec_valid) && o_kind == 3'h3 |-> o_new_prio == $past(i_cpu_prio);
   endproperty
   a_sw_prio: assert property (p_sw_prio) else $error("sw trap prio");
   // Level must beat the CPU level seen on the deciding edge
   property p_irq_lvl;
      $rose(o_vec_valid) && o_kind == 3'h4 |-> o_new_prio > $past(i_cpu_prio);
   endproperty
   a_irq_lvl: assert property (p_irq_lvl) else $error("irq level too low");
   property p_nmi;
      i_nmi && !o_hw_trap_active && !o_vec_valid |-> ##[2:4] o_vec_valid && o_trap_num == 7'h02;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not offered");
   property p_active;
      $rose(o_hw_trap_active) |-> $past(i_vec_ack) && $past(o_kind) inside {3'h1, 3'h2};
   endproperty
   a_active: assert property (p_active) else $error("trap service without ack");
   // Only the software trap may land on the unused numbers
   property p_rsv;
      o_vec_valid && o_kind != 3'h3 |-> !(o_trap_num inside {[7'h0b:7'h0f]});
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved trap from hardware");
endmodule // itv_top_properties
bind itv_top itv_top_properties u_itv_top_properties (.i_core_clk(i_core_clk),
   .i_nrst(i_nrst), .i_nmi(i_nmi), .i_vec_ack(i_vec_ack), .i_cpu_prio(i_cpu_prio),
   .o_vec_valid(o_vec_valid), .o_vec_addr(o_vec_addr), .o_trap_num(o_trap_num),
   .o_new_prio(o_new_prio), .o_kind(o_kind), .o_hw_trap_active(o_hw_trap_active));
`default_nettype wire

// file: tb/itv_cpu_model.sv
`default_nettype none
module itv_cpu_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_valid,
   input  wire logic       i_ret_req,
   input  wire logic [1:0] i_wait,
   output var  logic       o_ack,
   output var  logic       o_ret
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   // Stalls a chosen count, then acks once; never acks without a standing offer
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ack <= 1'b0;
         o_ret <= 1'b0;
         cnt   <= 2'h0;
      end else begin
         o_ret <= i_ret_req;
         o_ack <= i_valid && !o_ack && cnt >= i_wait;
         cnt   <= (i_valid && !o_ack && cnt < i_wait) ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule // itv_cpu_model
`default_nettype wire

// file: tb/tb_interrupt_trap_vectoring.sv
`default_nettype none
module tb_interrupt_trap_vectoring;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, swreq = 1'b0;
   logic [11:0] addr = '0;
   logic [15:0] wdata = '0, rdata, d;
   logic [10:0] cond = '0;
   logic [25:0] src = '0;
   logic [6:0]  swnum = '0, tnum;
   logic [3:0]  prio = '0, nx_prio = '0, nprio, lv;
   logic [1:0]  wt = '0;
   logic [23:0] vaddr;
   logic [2:0]  kind;
   logic        ack, ret, valid, hw_act, irq;
   logic [31:0] seed = 32'h3ab2d847;
   int          failures = 0;
   int          n_compared = 0;
   int          ix;
   always #2 clk = ~clk;
   itv_top u_itv_top (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_src_req(src), .i_nmi(cond[0]),
      .i_stack_over(cond[1]), .i_stack_under(cond[2]), .i_undef_opcode(cond[3]),
      .i_prot_fault(cond[4]), .i_illegal_operand(cond[5]), .i_illegal_instr(cond[6]),
      .i_illegal_bus(cond[7]), .i_sw_reset(cond[8]), .i_wdt_overflow(cond[9]),
      .i_swtrap_req(swreq), .i_swtrap_num(swnum), .i_cpu_prio(prio), .i_vec_ack(ack),
      .i_trap_return(ret), .o_vec_valid(valid), .o_vec_addr(vaddr), .o_trap_num(tnum),
      .o_new_prio(nprio), .o_kind(kind), .o_hw_trap_active(hw_act), .o_irq(irq));
   itv_cpu_model u_itv_cpu_model (.i_core_clk(clk), .i_nrst(nrst), .i_valid(valid),
      .i_ret_req(cond[10]), .i_wait(wt), .o_ack(ack), .o_ret(ret));
   //////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [6:0] exp_num(input int i);
      exp_num = (i < 3) ? 7'(2 + 2 * i) : 7'h0a;
   endfunction
   task automatic close_out;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // Bit 7 of sw raises the software trap, bits 6:0 give its number
   task automatic pulse(input logic [10:0] c, input logic [25:0] s, input logic [7:0] sw);
      @(posedge clk);
      cond <= c;
      src <= s;
      {swreq, swnum} <= sw;
      prio <= nx_prio;
      wt <= seed[1:0];
      @(posedge clk);
      cond <= '0;
      src <= '0;
      swreq <= 1'b0;
   endtask
   task automatic expect_offer(input logic [6:0] n, input logic [2:0] k, input logic [3:0] p);
      int i;
      i = 0;
      while (valid !== 1'b1 && i < 40) begin
         @(negedge clk);
         i++;
      end
      chk("trap number", 32'(n), 32'(tnum));
      chk("vector", {23'h0, n, 2'b00}, 32'(vaddr));
      chk("kind", 32'(k), 32'(kind));
      chk("priority", 32'(p), 32'(nprio));
      while (valid === 1'b1 && i < 80) begin
         @(negedge clk);
         i++;
      end
      if (i == 40 || i == 80) begin
         failures++;
         close_out();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      expect_offer(7'h00, 3'h0, 4'hf);
      wr_reg(12'h00c, 16'h000f);
      for (int i = 0; i < 8; i++) begin
         pulse(11'(1 << i), '0, 8'h00);
         expect_offer(exp_num(i), (i < 3) ? 3'h1 : 3'h2, 4'hf);
         chk("active", 1, 32'(hw_act));
         rd_reg(12'h000);
         chk("flags", 32'(1 << i), 32'(d));
         chk("irq", 1, 32'(irq));
         wr_reg(12'h008, 16'h000f);
         pulse(11'h400, '0, 8'h00);
         rd_reg(12'h000);
         chk("flags kept", 32'(1 << i), 32'(d));
         wr_reg(12'h000, 16'h00ff);
         rd_reg(12'h000);
         chk("flags cleared", 0, 32'(d));
         chk("irq cleared", 0, 32'(irq));
         chk("active end", 0, 32'(hw_act));
      end
      // Masked events must stay visible in status yet keep the line low
      wr_reg(12'h00c, 16'h0000);
      for (int i = 8; i < 10; i++) begin
         pulse(11'(1 << i), '0, 8'h00);
         expect_offer(7'h00, 3'h0, 4'hf);
      end
      rd_reg(12'h004);
      chk("event status", 32'h4, 32'(d));
      chk("irq masked", 0, 32'(irq));
      wr_reg(12'h00c, 16'h000f);
      rd_reg(12'h0f0);
      chk("unmapped", 0, 32'(d));
      chk("irq enabled", 1, 32'(irq));
      pulse(11'h084, '0, 8'h00);
      expect_offer(7'h06, 3'h1, 4'hf);
      pulse(11'h400, '0, 8'h00);
      expect_offer(7'h0a, 3'h2, 4'hf);
      pulse(11'h400, '0, 8'h00);
      wr_reg(12'h000, 16'h00ff);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         nx_prio = seed[10:7];
         pulse('0, '0, {1'b1, (i == 0) ? 7'h7f : (i == 1) ? 7'h0b : seed[6:0]});
         expect_offer(swnum, 3'h3, nx_prio);
      end
      nx_prio = 4'h2;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         ix = (i == 0) ? 0 : (i == 1) ? 20 : (i == 2) ? 21 : int'(seed[4:0] % 26);
         lv = 4'(3 + seed[12:9] % 13);
         wr_reg(12'h100 + 12'(4 * ix), 16'h0040 | 16'(lv));
         pulse('0, 26'(1) << ix, 8'h00);
         expect_offer((i == 0) ? 7'h24 : (i == 1) ? 7'h40 : (i == 2) ? 7'h43 :
            itv_pkg::SRC_TRAP[ix], 3'h4, lv);
      end
      nx_prio = 4'h4;
      pulse('0, '0, 8'h00);
      wr_reg(12'h114, 16'h00c4);
      repeat (12) @(posedge clk);
      chk("level held off", 0, 32'(valid));
      rd_reg(12'h114);
      chk("source control", 32'h00c4, 32'(d));
      nx_prio = 4'h3;
      pulse('0, '0, 8'h00);
      expect_offer(7'h2c, 3'h4, 4'h4);
      pulse(11'h001, '0, 8'h00);
      expect_offer(7'h02, 3'h1, 4'hf);
      wr_reg(12'h100, 16'h0049);
      pulse('0, 26'h1, 8'h00);
      repeat (12) @(posedge clk);
      chk("irq held off", 0, 32'(valid));
      rd_reg(12'h010);
      chk("service", 32'h0002, 32'(d));
      pulse(11'h400, '0, 8'h00);
      expect_offer(7'h24, 3'h4, 4'h9);
      close_out();
   end
endmodule // tb_interrupt_trap_vectoring
`default_nettype wire
